// ### obl_option_bit_loader.v
// Operation
// - Load configuration from flash every reset
// - Configuration comes only from bytes 0000h, 0001h
// - Page 0 erase also clears configuration
// - New configuration acts only after reset
// - Factory trims live in information page
// - Trim working copies reloaded at reset
// - Trim data write updates working copy only
// - Trim data read returns working copy
// - Bit 7 picks watchdog interrupt or reset
// - Bit 6 low starts watchdog automatically
// - Bits 5:4 select crystal drive
// - Bit 3 keeps brownout on in halt
// - Bit 2 low blocks external reads
// - Bit 0 low guards flash writes
// - Trims reloaded after halt recovery too
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`include "obl_regs.vh"
module obl_option_bit_loader (
  // Clock and reset
  input wire CLOCK,
  input wire SRST,
  // Halt recovery pulse, same clock
  input wire HALT_WAKE,
  // Flash read port
  output reg FLASH_RD,
  output reg [15:0] FLASH_ADDR,
  input wire [7:0] FLASH_RDATA,
  input wire FLASH_VALID,
  // APB slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output wire PREADY,
  output reg [31:0] PRDATA,
  output wire PSLVERR,
  // Applied configuration
  output wire CPU_RELEASE,
  output wire WATCHDOG_TIMEOUT_ACTION,
  output wire WATCHDOG_AUTO_START,
  output wire [1:0] CRYSTAL_DRIVE_SELECT,
  output wire BROWNOUT_KEEP_ON,
  output wire EXTERNAL_READ_BLOCK,
  output wire FLASH_WRITE_GUARD,
  output wire [7:0] CONFIG_BYTE_ONE,
  output wire [255:0] TRIM_VALUES
);
  // ----------------------------------------
  // Loader state
  // ----------------------------------------
  localparam ST_CFG0 = 2'd0;
  localparam ST_CFG1 = 2'd1;
  localparam ST_TRIM = 2'd2;
  localparam ST_DONE = 2'd3;
  reg [1:0] state;
  reg [1:0] next_state;
  reg [4:0] trim_idx;
  reg [7:0] cfg0;
  reg [7:0] cfg1;
  reg [7:0] trim_mem [0:`OBL_TRIM_ENTRIES-1];
  reg [4:0] trim_sel;
  reg loaded;
  wire apb_wr;
  wire apb_rd;
  wire flash_busy;
  reg halt_pending;
  reg [6:0] cfg_out;
  reg [7:0] cfg1_out;
  reg [31:0] next_prdata;
  wire [31:0] load_hit;
  wire [31:0] cpu_hit;

  // Unmapped access is flagged once ready, early access only stalls; decode used twice
  function is_mapped;
    input [11:0] a;
    begin
      is_mapped = (a == `OBL_ADDR_CFG0) || (a == `OBL_ADDR_CFG1) ||
        (a == `OBL_ADDR_TRIM_ADDR) || (a == `OBL_ADDR_TRIM_DATA) ||
        (a == `OBL_ADDR_STATUS);
    end
  endfunction

  // Polarity of each field is fixed here once; used at reset and load
  function [6:0] decode_cfg;
    input [7:0] b;
    begin
      decode_cfg = {
        b[`OBL_BIT_WDT_ACTION],
        !b[`OBL_BIT_WDT_AUTO],
        b[`OBL_BIT_XTAL_HI:`OBL_BIT_XTAL_LO],
        b[`OBL_BIT_BROWNOUT],
        !b[`OBL_BIT_READ_BLOCK],
        !b[`OBL_BIT_WRITE_GUARD]
      };
    end
  endfunction

  // A pending wake keeps the bus stalled; PRDATA is latched in the setup phase, so a read set up before the reload ends sees the old trim
  assign flash_busy = (state != ST_DONE) || halt_pending;
  // Zero wait states once loaded; during a load the bus stalls
  assign PREADY = !flash_busy;
  assign PSLVERR = PSEL && PENABLE && PREADY && !is_mapped(PADDR);
  assign apb_wr = PSEL && PENABLE && PREADY && PWRITE && is_mapped(PADDR);
  assign apb_rd = PSEL && !PENABLE && !PWRITE;

  // ----------------------------------------
  // Fetch sequencer
  // ----------------------------------------
  always @* begin
    next_state = state;
    case (state)
      ST_CFG0: begin
        if (FLASH_VALID) begin
          next_state = ST_CFG1;
        end
      end
      ST_CFG1: begin
        if (FLASH_VALID) begin
          next_state = ST_TRIM;
        end
      end
      ST_TRIM: begin
        if (FLASH_VALID && trim_idx == `OBL_TRIM_LAST) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        if (HALT_WAKE || halt_pending) begin
          next_state = ST_TRIM;
        end
      end
      default: begin
        next_state = ST_CFG0;
      end
    endcase
  end

  always @(posedge CLOCK) begin
    if (SRST) begin
      state <= ST_CFG0;
      FLASH_RD <= 1'b0;
    end else begin
      state <= next_state;
      FLASH_RD <= (next_state != ST_DONE);
    end
  end

  // ----------------------------------------
  // Halt recovery
  // ----------------------------------------
  // A wake during a load would be lost; remember it and reload later
  always @(posedge CLOCK) begin
    if (SRST) begin
      halt_pending <= 1'b0;
    end else if (HALT_WAKE && flash_busy) begin
      halt_pending <= 1'b1;
    end else if (state == ST_DONE) begin
      halt_pending <= 1'b0;
    end
  end

  // Address walks 0000h, 0001h, then the information page
  always @(posedge CLOCK) begin
    if (SRST) begin
      FLASH_ADDR <= `OBL_FLASH_CFG0;
    end else begin
      case (state)
        ST_CFG0: begin
          if (FLASH_VALID) begin
            FLASH_ADDR <= `OBL_FLASH_CFG1;
          end else begin
            FLASH_ADDR <= `OBL_FLASH_CFG0;
          end
        end
        ST_CFG1: begin
          if (FLASH_VALID) begin
            FLASH_ADDR <= `OBL_INFO_BASE;
          end
        end
        ST_TRIM: begin
          if (FLASH_VALID) begin
            FLASH_ADDR <= `OBL_INFO_BASE + {11'h000, trim_idx + 5'h01};
          end
        end
        ST_DONE: begin
          if (HALT_WAKE || halt_pending) begin
            FLASH_ADDR <= `OBL_INFO_BASE;
          end
        end
        default: begin
          FLASH_ADDR <= `OBL_FLASH_CFG0;
        end
      endcase
    end
  end

  always @(posedge CLOCK) begin
    if (SRST) begin
      trim_idx <= 5'h00;
    end else begin
      case (state)
        ST_CFG1: begin
          if (FLASH_VALID) begin
            trim_idx <= 5'h00;
          end
        end
        ST_TRIM: begin
          if (FLASH_VALID) begin
            trim_idx <= trim_idx + 5'h01;
          end
        end
        ST_DONE: begin
          if (HALT_WAKE || halt_pending) begin
            trim_idx <= 5'h00;
          end
        end
        default: begin
          trim_idx <= trim_idx;
        end
      endcase
    end
  end

  // Bytes are latched only here, so a later flash program or
  // page 0 erase shows up after the next reset
  always @(posedge CLOCK) begin
    if (SRST) begin
      cfg0 <= `OBL_CFG_RESET;
      cfg1 <= `OBL_CFG_RESET;
    end else begin
      if (state == ST_CFG0 && FLASH_VALID) begin
        cfg0 <= FLASH_RDATA;
      end
      if (state == ST_CFG1 && FLASH_VALID) begin
        cfg1 <= FLASH_RDATA;
      end
    end
  end

  // Set once the first trim pass starts; release also needs DONE
  always @(posedge CLOCK) begin
    if (SRST) begin
      loaded <= 1'b0;
    end else if (state == ST_TRIM) begin
      loaded <= 1'b1;
    end
  end

  // ----------------------------------------
  // Trim working copies
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < `OBL_TRIM_ENTRIES; g = g + 1) begin : trim_gen
      localparam [4:0] IDX = g;
      // Flash reload has priority over a CPU write in the same cycle
      assign load_hit[g] = (state == ST_TRIM) && FLASH_VALID &&
        (trim_idx == IDX);
      assign cpu_hit[g] = apb_wr && (PADDR == `OBL_ADDR_TRIM_DATA) &&
        (trim_sel == IDX);
      always @(posedge CLOCK) begin
        if (SRST) begin
          trim_mem[g] <= `OBL_TRIM_RESET;
        end else if (load_hit[g]) begin
          trim_mem[g] <= FLASH_RDATA;
        end else if (cpu_hit[g]) begin
          trim_mem[g] <= PWDATA[7:0];
        end
      end
      assign TRIM_VALUES[g*8+7:g*8] = trim_mem[g];
    end
  endgenerate

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  always @(posedge CLOCK) begin
    if (SRST) begin
      trim_sel <= 5'h00;
      PRDATA <= 32'h00000000;
    end else begin
      if (apb_wr && PADDR == `OBL_ADDR_TRIM_ADDR) begin
        // Only 32 entries exist; upper index bits are dropped
        trim_sel <= PWDATA[4:0];
      end
      if (apb_rd) begin
        PRDATA <= next_prdata;
      end
    end
  end

  always @* begin
    case (PADDR)
      `OBL_ADDR_CFG0: begin
        next_prdata = {24'h000000, cfg0};
      end
      `OBL_ADDR_CFG1: begin
        next_prdata = {24'h000000, cfg1};
      end
      `OBL_ADDR_TRIM_ADDR: begin
        next_prdata = {27'h0000000, trim_sel};
      end
      `OBL_ADDR_TRIM_DATA: begin
        next_prdata = {24'h000000, trim_mem[trim_sel]};
      end
      `OBL_ADDR_STATUS: begin
        next_prdata = {29'h00000000, loaded, state};
      end
      default: begin
        next_prdata = 32'h00000000;
      end
    endcase
  end

  // ----------------------------------------
  // Configuration outputs
  // ----------------------------------------
  // Registered so the pins never glitch while cfg0 is loading; they
  // trail cfg0 by one cycle, long before the CPU is released
  always @(posedge CLOCK) begin
    if (SRST) begin
      cfg_out <= decode_cfg(`OBL_CFG_RESET);
      cfg1_out <= `OBL_CFG_RESET;
    end else begin
      cfg_out <= decode_cfg(cfg0);
      cfg1_out <= cfg1;
    end
  end

  // Held in reset until the first trim pass completes
  assign CPU_RELEASE = loaded && !flash_busy;
  assign WATCHDOG_TIMEOUT_ACTION = cfg_out[6];
  assign WATCHDOG_AUTO_START = cfg_out[5];
  assign CRYSTAL_DRIVE_SELECT = cfg_out[4:3];
  assign BROWNOUT_KEEP_ON = cfg_out[2];
  // Bit 1 is not decoded; its value is the programmer's concern
  assign EXTERNAL_READ_BLOCK = cfg_out[1];
  assign FLASH_WRITE_GUARD = cfg_out[0];
  assign CONFIG_BYTE_ONE = cfg1_out;
endmodule // obl_option_bit_loader

// ### obl_regs.vh
`ifndef OBL_REGS_VH
`define OBL_REGS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OBL_ADDR_CFG0 12'h000
`define OBL_ADDR_CFG1 12'h004
`define OBL_ADDR_TRIM_ADDR 12'h008
`define OBL_ADDR_TRIM_DATA 12'h00c
`define OBL_ADDR_STATUS 12'h010
// ----------------------------------------
// Flash locations
// ----------------------------------------
`define OBL_FLASH_CFG0 16'h0000
`define OBL_FLASH_CFG1 16'h0001
`define OBL_INFO_BASE 16'hfe20
// ----------------------------------------
// Configuration byte zero fields
// ----------------------------------------
`define OBL_BIT_WDT_ACTION 7
`define OBL_BIT_WDT_AUTO 6
`define OBL_BIT_XTAL_HI 5
`define OBL_BIT_XTAL_LO 4
`define OBL_BIT_BROWNOUT 3
`define OBL_BIT_READ_BLOCK 2
`define OBL_BIT_WRITE_GUARD 0
// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define OBL_CFG_RESET 8'hff
`define OBL_TRIM_RESET 8'h00
`define OBL_TRIM_ENTRIES 32
`define OBL_TRIM_LAST 5'h1f
`endif

// ### obl_flash_model.sv
`timescale 1ns/1ps
module obl_flash_model (
  // Loader side
  input wire CLOCK,
  input wire FLASH_RD,
  input wire [15:0] FLASH_ADDR,
  output logic [7:0] FLASH_RDATA = 8'h00,
  output logic FLASH_VALID = 1'b0,
  // Stored configuration bytes
  input wire [7:0] cfg0,
  input wire [7:0] cfg1
);
  // Every other cycle only; idle data scrambled so stale bytes never pass
  always @(posedge CLOCK) begin
    FLASH_VALID <= FLASH_RD && !FLASH_VALID;
    if (FLASH_RD && !FLASH_VALID)
      FLASH_RDATA <= FLASH_ADDR == 16'h0 ? cfg0 :
        FLASH_ADDR == 16'h1 ? cfg1 : FLASH_ADDR[7:0] ^ 8'ha5;
    else
      FLASH_RDATA <= ~FLASH_RDATA;
  end
endmodule // obl_flash_model

// ### obl_loader_assertions.sv
`timescale 1ns/1ps
module obl_loader_assertions (
  // Clock and reset
  input wire CLOCK,
  input wire SRST,
  // Loader side
  input wire HALT_WAKE,
  input wire FLASH_RD,
  input wire FLASH_VALID,
  input wire [15:0] FLASH_ADDR,
  input wire PREADY,
  input wire CPU_RELEASE,
  input wire [7:0] CONFIG_BYTE_ONE
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SRST);
  a_ready_done: assert property (PREADY == CPU_RELEASE)
    else $error("ready differs from release");
  a_hold_cpu: assert property (FLASH_RD |-> !CPU_RELEASE)
    else $error("cpu released while loading");
  a_load_start: assert property ($fell(SRST) |=>
    FLASH_RD && FLASH_ADDR == 16'h0) else $error("no load after reset");
  a_addr_range: assert property (FLASH_RD |-> FLASH_ADDR < 2 ||
    FLASH_ADDR[15:5] == 11'h7f1) else $error("fetch outside map");
  a_addr_step: assert property (FLASH_VALID && FLASH_RD &&
    FLASH_ADDR == 16'h0 |-> ##[1:2] FLASH_ADDR == 16'h1)
    else $error("no step to second byte");
  a_cfg_frozen: assert property (CPU_RELEASE |=>
    $stable(CONFIG_BYTE_ONE)) else $error("config changed without reset");
  a_halt_trims: assert property (HALT_WAKE && CPU_RELEASE |->
    ##[1:2] FLASH_RD && FLASH_ADDR == 16'hfe20) else $error("no trim reload");
  a_load_bound: assert property ($rose(FLASH_RD) |->
    ##[1:300] !FLASH_RD) else $error("load never ends");
endmodule // obl_loader_assertions
bind obl_option_bit_loader obl_loader_assertions u_chk (.*);

// ### obl_option_bit_loader_test.sv
`timescale 1ns/1ps
`include "obl_regs.vh"
module obl_option_bit_loader_test;
  logic CLOCK = 0, SRST = 1, HALT_WAKE = 0, PSEL = 0, PENABLE = 0;
  logic PWRITE = 0, FLASH_RD, FLASH_VALID, PREADY, PSLVERR, CPU_RELEASE;
  logic WATCHDOG_TIMEOUT_ACTION, WATCHDOG_AUTO_START, BROWNOUT_KEEP_ON;
  logic EXTERNAL_READ_BLOCK, FLASH_WRITE_GUARD, err;
  logic [1:0] CRYSTAL_DRIVE_SELECT;
  logic [7:0] FLASH_RDATA, CONFIG_BYTE_ONE, v, cfg0 = 8'h5a, cfg1 = 8'hc3;
  logic [11:0] PADDR = 0;
  logic [15:0] FLASH_ADDR;
  logic [31:0] PWDATA = 0, PRDATA, rd;
  logic [255:0] TRIM_VALUES;
  int fails = 0, tests_run = 0;
  localparam logic [11:0] TD = `OBL_ADDR_TRIM_DATA;
  obl_option_bit_loader u_obl_option_bit_loader (.*);
  obl_flash_model u_obl_flash_model (.*);
  function automatic logic [7:0] tv(input int n);
    return 8'(n + 32) ^ 8'ha5;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("compares %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Bounded waits: a hung loader ends the run instead of stalling it
  task automatic wait_release;
    int k;
    for (k = 0; k < 500 && CPU_RELEASE !== 1'b1; k++)
      @(negedge CLOCK);
    if (k == 500) begin
      fails++;
      summarize();
    end
    @(posedge CLOCK);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input int d);
    int k;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    @(negedge CLOCK);
    for (k = 0; k < 100 && PREADY !== 1'b1; k++)
      @(negedge CLOCK);
    if (k == 100) begin
      fails++;
      summarize();
    end
    @(posedge CLOCK);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLOCK);
  endtask
  initial forever #2 CLOCK = ~CLOCK;
  initial begin
    for (int i = 0; i < 2; i++) begin
      SRST <= 1'b1;
      repeat (3) @(posedge CLOCK);
      SRST <= 1'b0;
      v = cfg0;
      wait_release();
      chk(v[1], 1'b1);
      chk(WATCHDOG_TIMEOUT_ACTION, v[7]);
      chk(WATCHDOG_AUTO_START, !v[6]);
      chk(CRYSTAL_DRIVE_SELECT, v[5:4]);
      chk(BROWNOUT_KEEP_ON, v[3]);
      chk(EXTERNAL_READ_BLOCK, !v[2]);
      chk(FLASH_WRITE_GUARD, !v[0]);
      chk(CONFIG_BYTE_ONE, cfg1);
      apb(1'b0, `OBL_ADDR_CFG0, 0);
      chk(rd, {24'h0, v});
      chk(err, 1'b0);
      apb(1'b0, `OBL_ADDR_STATUS, 0);
      chk(rd, 32'h7);
      apb(1'b0, 12'h014, 0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
      for (int n = 0; n < 32; n += 31) begin
        apb(1'b1, `OBL_ADDR_TRIM_ADDR, n);
        apb(1'b0, TD, 0);
        chk(rd, {24'h0, tv(n)});
      end
      chk(TRIM_VALUES[255:248], tv(31));
      apb(1'b1, TD, 'h3c);
      apb(1'b0, TD, 0);
      chk(rd, 32'h3c);
      chk(TRIM_VALUES[255:248], 8'h3c);
      HALT_WAKE <= 1'b1;
      @(posedge CLOCK);
      HALT_WAKE <= 1'b0;
      repeat (4) @(posedge CLOCK);
      // A second wake inside the reload must not be lost
      HALT_WAKE <= 1'b1;
      @(posedge CLOCK);
      HALT_WAKE <= 1'b0;
      repeat (2) @(posedge CLOCK);
      wait_release();
      apb(1'b0, TD, 0);
      chk(rd, {24'h0, tv(31)});
      apb(1'b1, TD, 'h3c);
      cfg0 <= 8'ha7;
      repeat (2) @(posedge CLOCK);
      chk(WATCHDOG_TIMEOUT_ACTION, v[7]);
      chk(FLASH_WRITE_GUARD, !v[0]);
    end
    summarize();
  end
endmodule // obl_option_bit_loader_test
